// File: design/lbaa_consts.svh
`ifndef LBAA_CONSTS_SVH
`define LBAA_CONSTS_SVH

// clock and observation timing
`define LBAA_CLK_HZ         64'd20000000
`define LBAA_CYCLE_MS       64'd128
`define LBAA_CYCLE_CLKS     ((`LBAA_CYCLE_MS * `LBAA_CLK_HZ) / 64'd1000)

// register offsets
`define LBAA_ADDR_RAISE     8'h54
`define LBAA_ADDR_CLEAR     8'h55
`define LBAA_ADDR_SIZE      8'h56
`define LBAA_ADDR_DECAY     8'h57
`define LBAA_ADDR_STATE     8'h58
`define LBAA_ADDR_ACC       8'h59
`define LBAA_ADDR_INT_STS   8'h5a
`define LBAA_ADDR_INT_MASK  8'h5b

// reset values
`define LBAA_RST_RAISE      8'h06
`define LBAA_RST_CLEAR      8'h04
`define LBAA_RST_SIZE       8'h08
`define LBAA_RST_DECAY      2'h1
`define LBAA_RST_MASK       8'h00

// field positions
`define LBAA_DECAY_MSB      1
`define LBAA_ST_ALARM       0
`define LBAA_ST_FAULT       1
`define LBAA_INT_RAISE      0
`define LBAA_INT_CLEAR      1
`define LBAA_INT_CYCLE      2
`define LBAA_INT_BITS       3

`endif

// File: design/lbaa_pkg.sv
package lbaa_pkg;

	typedef logic [7:0] lbaa_byte_t;
	typedef logic [3:0] lbaa_quiet_t;

	// decay period selection, one decrement per 128/256/512/1024 ms
	typedef enum logic [1:0] {
		LBAA_DECAY_1 = 2'h0,
		LBAA_DECAY_2 = 2'h1,
		LBAA_DECAY_4 = 2'h2,
		LBAA_DECAY_8 = 2'h3
	} lbaa_decay_e;

endpackage : lbaa_pkg

// File: design/lbaa_obs_if.sv
`timescale 1ns/1ps

interface lbaa_obs_if;
	logic cyc_end;
	logic cyc_fault;

	modport timer (output cyc_end, output cyc_fault);
	modport user  (input cyc_end, input cyc_fault);
endinterface : lbaa_obs_if

// File: design/lbaa_obs.sv
`timescale 1ns/1ps
`include "lbaa_consts.svh"

module lbaa_obs #(
	parameter int unsigned CYCLE_CLKS = 32'(`LBAA_CYCLE_CLKS)
) (
	// clock and reset
	input  wire logic      clock,
	input  wire logic      sys_rst,
	// synchronised fault level
	input  wire logic      fault_lvl,
	// end of cycle report
	lbaa_obs_if.timer      obs
);

	logic [31:0] cyc_cnt;
	logic        fault_seen;
	logic        cyc_last;

	assign cyc_last = (cyc_cnt == CYCLE_CLKS - 32'd1);

	// fixed observation cycle, one verdict per cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cyc_cnt       <= 32'h0;
			fault_seen    <= 1'b0;
			obs.cyc_end   <= 1'b0;
			obs.cyc_fault <= 1'b0;
		end else begin
			cyc_cnt       <= cyc_last ? 32'h0 : cyc_cnt + 32'd1;
			fault_seen    <= cyc_last ? 1'b0 : (fault_seen | fault_lvl);
			obs.cyc_end   <= cyc_last;
			obs.cyc_fault <= fault_seen | fault_lvl;
		end
	end

endmodule : lbaa_obs

// File: design/lbaa_top.sv
`timescale 1ns/1ps
`include "lbaa_consts.svh"

module lbaa_top #(
	parameter int unsigned CYCLE_CLKS = 32'(`LBAA_CYCLE_CLKS)
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// monitored reference status pin, high when failed or erratic
	input  wire logic               fault_in,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output      logic [7:0]         reg_rdata,
	// alarm and interrupt
	output      logic               alarm,
	output      logic               irq
);

	// pin synchroniser, three stages
	logic                  sync1;
	logic                  sync2;
	logic                  sync3;
	logic                  fault_lvl;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= fault_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a change counts once stages two and three agree
	logic                  next_fault_lvl;

	assign next_fault_lvl = (sync2 == sync3) ? sync3 : fault_lvl;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fault_lvl <= 1'b0;
		end else begin
			fault_lvl <= next_fault_lvl;
		end
	end

	// observation cycle timer
	lbaa_obs_if obs_bus ();

	lbaa_obs #(
		.CYCLE_CLKS (CYCLE_CLKS)
	) u_obs (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.fault_lvl (fault_lvl),
		.obs       (obs_bus.timer)
	);

	// registers
	lbaa_pkg::lbaa_byte_t  raise_lim;
	lbaa_pkg::lbaa_byte_t  clear_lim;
	lbaa_pkg::lbaa_byte_t  bucket_size;
	lbaa_pkg::lbaa_decay_e decay_sel;
	lbaa_pkg::lbaa_byte_t  acc;
	lbaa_pkg::lbaa_quiet_t quiet_cnt;
	logic                  last_fault;
	logic [`LBAA_INT_BITS-1:0] int_sts;
	logic [`LBAA_INT_BITS-1:0] int_mask;

	// register decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	logic                  wr_raise;
	logic                  wr_clear;
	logic                  wr_size;
	logic                  wr_decay;
	logic                  wr_mask;
	logic                  rd_sts;

	assign wr_raise = reg_wr && hit(reg_addr, `LBAA_ADDR_RAISE);
	assign wr_clear = reg_wr && hit(reg_addr, `LBAA_ADDR_CLEAR);
	assign wr_size  = reg_wr && hit(reg_addr, `LBAA_ADDR_SIZE);
	assign wr_decay = reg_wr && hit(reg_addr, `LBAA_ADDR_DECAY);
	assign wr_mask  = reg_wr && hit(reg_addr, `LBAA_ADDR_INT_MASK);
	assign rd_sts   = reg_rd && hit(reg_addr, `LBAA_ADDR_INT_STS);

	// software-writable configuration
	lbaa_pkg::lbaa_byte_t  next_raise;
	lbaa_pkg::lbaa_byte_t  next_clear;
	lbaa_pkg::lbaa_byte_t  next_size;
	lbaa_pkg::lbaa_decay_e next_decay;
	logic [`LBAA_INT_BITS-1:0] next_mask;

	assign next_raise = wr_raise ? reg_wdata : raise_lim;
	assign next_clear = wr_clear ? reg_wdata : clear_lim;
	assign next_size  = wr_size ? reg_wdata : bucket_size;
	assign next_decay = wr_decay
		? lbaa_pkg::lbaa_decay_e'(reg_wdata[`LBAA_DECAY_MSB:0])
		: decay_sel;
	assign next_mask  = wr_mask ? reg_wdata[`LBAA_INT_BITS-1:0] : int_mask;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			raise_lim <= `LBAA_RST_RAISE;
		end else begin
			raise_lim <= next_raise;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			clear_lim <= `LBAA_RST_CLEAR;
		end else begin
			clear_lim <= next_clear;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bucket_size <= `LBAA_RST_SIZE;
		end else begin
			bucket_size <= next_size;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			decay_sel <= lbaa_pkg::lbaa_decay_e'(`LBAA_RST_DECAY);
		end else begin
			decay_sel <= next_decay;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			int_mask <= `LBAA_INT_BITS'(`LBAA_RST_MASK);
		end else begin
			int_mask <= next_mask;
		end
	end

	// quiet cycles needed for one decrement
	function automatic lbaa_pkg::lbaa_quiet_t quiet_need(
		input lbaa_pkg::lbaa_decay_e code
	);
		quiet_need = 4'h1 << code;
	endfunction : quiet_need

	// accumulator next state
	lbaa_pkg::lbaa_byte_t  next_acc;
	lbaa_pkg::lbaa_quiet_t next_quiet;
	lbaa_pkg::lbaa_quiet_t quiet_inc;
	logic                  at_top;
	logic                  at_zero;
	logic                  quiet_done;

	assign quiet_inc  = quiet_cnt + 4'h1;
	assign at_top     = (acc >= bucket_size);
	assign at_zero    = (acc == 8'h00);
	assign quiet_done = (quiet_inc >= quiet_need(decay_sel));

	always_comb begin
		next_acc   = acc;
		next_quiet = quiet_cnt;
		if (obs_bus.cyc_end) begin
			if (obs_bus.cyc_fault) begin
				next_quiet = 4'h0;
				if (!at_top) next_acc = acc + 8'h01;
				else next_acc = bucket_size;
			end else if (quiet_done) begin
				next_quiet = 4'h0;
				if (!at_zero) next_acc = acc - 8'h01;
			end else begin
				next_quiet = quiet_inc;
			end
		end
	end

	// verdict of the last completed cycle
	logic                  next_last_fault;

	assign next_last_fault = obs_bus.cyc_end
		? obs_bus.cyc_fault : last_fault;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			acc <= 8'h00;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			quiet_cnt <= 4'h0;
		end else begin
			quiet_cnt <= next_quiet;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			last_fault <= 1'b0;
		end else begin
			last_fault <= next_last_fault;
		end
	end

	// alarm with hysteresis
	logic                  raise_hit;
	logic                  clear_hit;
	logic                  next_alarm;

	assign raise_hit  = (next_acc >= raise_lim);
	assign clear_hit  = (next_acc <= clear_lim);
	assign next_alarm = alarm ? !clear_hit : raise_hit;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarm <= 1'b0;
		end else begin
			alarm <= next_alarm;
		end
	end

	// interrupt events; a set in the clearing cycle wins
	logic [`LBAA_INT_BITS-1:0] int_evt;
	logic [`LBAA_INT_BITS-1:0] next_sts;

	assign int_evt[`LBAA_INT_RAISE] = next_alarm && !alarm;
	assign int_evt[`LBAA_INT_CLEAR] = !next_alarm && alarm;
	assign int_evt[`LBAA_INT_CYCLE] = obs_bus.cyc_end;
	assign next_sts = (rd_sts ? '0 : int_sts) | int_evt;

	logic                  next_irq;

	assign next_irq = |(next_sts & int_mask);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			int_sts <= '0;
		end else begin
			int_sts <= next_sts;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// read data, one cycle after the strobe
	lbaa_pkg::lbaa_byte_t  rd_mux;
	lbaa_pkg::lbaa_byte_t  state_word;

	assign state_word = {6'h00, last_fault, alarm};

	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			`LBAA_ADDR_RAISE:    rd_mux = raise_lim;
			`LBAA_ADDR_CLEAR:    rd_mux = clear_lim;
			`LBAA_ADDR_SIZE:     rd_mux = bucket_size;
			`LBAA_ADDR_DECAY:    rd_mux = {6'h00, decay_sel};
			`LBAA_ADDR_STATE:    rd_mux = state_word;
			`LBAA_ADDR_ACC:      rd_mux = acc;
			`LBAA_ADDR_INT_STS:  rd_mux = 8'(int_sts);
			`LBAA_ADDR_INT_MASK: rd_mux = 8'(int_mask);
			default:             rd_mux = 8'h00;
		endcase
	end

	lbaa_pkg::lbaa_byte_t  next_rdata;

	assign next_rdata = reg_rd ? rd_mux : 8'h00;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : lbaa_top

// File: test/lbaa_top_properties.sv
`timescale 1ns/1ps
module lbaa_top_properties #(
	parameter int unsigned CYCLE_CLKS = 16
) (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       fault_in,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       alarm,
	input wire logic       irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_wr_rd(logic [7:0] a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
		!alarm && !irq && reg_rdata == 8'h00) else $error("not quiet");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	unmapped_zero_a: assert property (reg_rd &&
		(reg_addr < 8'h54 || reg_addr > 8'h5b) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	raise_rw_a: assert property (s_wr_rd(8'h54) |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("raise limit");
	clear_rw_a: assert property (s_wr_rd(8'h55) |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("clear limit");
	decay_rw_a: assert property (s_wr_rd(8'h57) |=>
		reg_rdata == ($past(reg_wdata, 2) & 8'h03)) else $error("decay");
	state_read_a: assert property (reg_rd && reg_addr == 8'h58 |=>
		reg_rdata[0] == $past(alarm) && reg_rdata[7:2] == 6'h00)
		else $error("state read");
	alarm_hold_a: assert property ($changed(alarm) |=>
		$stable(alarm) [*4]) else $error("alarm toggles");
endmodule : lbaa_top_properties

bind lbaa_top lbaa_top_properties #(.CYCLE_CLKS(CYCLE_CLKS)) i_props (
	.clock(clock), .sys_rst(sys_rst), .fault_in(fault_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm(alarm), .irq(irq));

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int unsigned CYC = 16;
	logic       clock;
	logic       sys_rst   = 1'b1;
	logic       fault_in  = 1'b0;
	logic [7:0] reg_addr  = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic [7:0] reg_rdata;
	logic       alarm;
	logic       irq;
	int         miscompares = 0;
	int         checks_done = 0;
	int         ncyc        = 0;
	logic [7:0] d;

	lbaa_top #(.CYCLE_CLKS(CYC)) i_dut (.clock(clock), .sys_rst(sys_rst),
		.fault_in(fault_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.alarm(alarm), .irq(irq));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) ncyc <= ncyc + 1;

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task wr_rd(input logic [7:0] a, input logic [7:0] v,
		output logic [7:0] r);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask : wr_rd
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task wait_alarm(input logic v);
		for (int i = 0; i < 40 * CYC && alarm !== v; i++) @(posedge clock);
		chk({7'h00, alarm}, {7'h00, v});
	endtask : wait_alarm
	task t_regs;
		logic [7:0] a [7] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h5b, 8'h10, 8'h59};
		logic [7:0] e [7] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) begin
			rd(a[i], d);
			chk(d, e[i]);
		end
		wr_rd(8'h54, 8'ha5, d);
		chk(d, 8'ha5);
		wr_rd(8'h55, 8'h5a, d);
		chk(d, 8'h5a);
		wr_rd(8'h56, 8'h0c, d);
		chk(d, 8'h0c);
		wr_rd(8'h57, 8'hfe, d);
		chk(d, 8'h02);
		wr(8'h54, 8'h06);
		wr(8'h55, 8'h04);
		wr(8'h56, 8'h08);
		wr(8'h59, 8'hff);
		rd(8'h59, d);
		chk(d, 8'h00);
		$display("register test done");
	endtask : t_regs
	task t_alarm;
		wr(8'h5b, 8'h01);
		wr(8'h57, 8'h00);
		fault_in <= 1'b1;
		wait_alarm(1'b1);
		rd(8'h59, d);
		chk(d, 8'h06);
		chk({7'h00, irq}, 8'h01);
		rd(8'h58, d);
		chk(d, 8'h03);
		repeat (4 * CYC) @(posedge clock);
		rd(8'h59, d);
		chk(d, 8'h08);
		rd(8'h5a, d);
		chk(d & 8'h01, 8'h01);
		repeat (2) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		fault_in <= 1'b0;
		wait_alarm(1'b0);
		rd(8'h59, d);
		chk(d, 8'h04);
		chk({7'h00, irq}, 8'h00);
		rd(8'h58, d);
		chk(d, 8'h00);
		rd(8'h5a, d);
		chk(d & 8'h06, 8'h06);
		repeat (6 * CYC) @(posedge clock);
		rd(8'h59, d);
		chk(d, 8'h00);
		wr(8'h5b, 8'h04);
		repeat (CYC + 2) @(posedge clock);
		chk({7'h00, irq}, 8'h01);
		wr(8'h5b, 8'h01);
		repeat (2) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		$display("alarm test done");
	endtask : t_alarm
	task t_decay;
		logic [7:0] v;
		int         t0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			fault_in <= 1'b1;
			repeat (10 * CYC) @(posedge clock);
			fault_in <= 1'b0;
			wr(8'h57, 8'(k));
			rd(8'h59, v);
			d = v;
			for (int i = 0; i < 300 && d === v; i++) rd(8'h59, d);
			t0 = ncyc;
			for (int i = 0; i < 300 && d !== v - 8'h02; i++) rd(8'h59, d);
			chk(8'(ncyc - t0), 8'(CYC << k));
		end
		$display("decay test done");
	endtask : t_decay
	task t_reset;
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk({6'h00, alarm, irq}, 8'h00);
		rd(8'h59, d);
		chk(d, 8'h00);
		rd(8'h57, d);
		chk(d, 8'h01);
		$display("reset test done");
	endtask : t_reset
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_alarm;
		t_decay;
		t_reset;
		complete_run;
	end
	initial begin
		repeat (6000) @(posedge clock);
		miscompares++;
		complete_run;
	end
endmodule : tb
